// *** rtl/plris_top.sv ***
/*
 Dual PLL reference input selector with divider configuration registers.
 Assumes reference clocks and the select pin comparators are asynchronous
 to core_clk_in; the register master follows the plain strobe protocol.
*/
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module plris_top (
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [3:0]        addr_in,
   input  wire logic [31:0]       wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [31:0]       rdata_out,
   input  wire logic              primary_reference_in,
   input  wire logic              secondary_reference_in,
   input  wire logic              pin_above_low_in,
   input  wire logic              pin_above_mid_in,
   input  wire logic [1:0]        pll_lock_in,
   output logic [1:0]             pll_ref_out,
   output logic [1:0]             sel_secondary_out,
   output logic                   both_refs_lost_flag_out,
   output logic                   pll_out_disable_out,
   output logic                   secondary_path_en_out,
   output logic [1:0]             channel_mute_enable_out,
   output logic [1:0][2:0]        pre_div_out,
   output logic [1:0]             doubler_en_out,
   output logic [1:0][4:0]        ref_div_out,
   output logic [1:0][2:0]        post_div_out,
   output logic [1:0][7:0]        output_divide_value_out,
   output logic [1:0][11:0]       fb_int_out,
   output logic [1:0][21:0]       fb_num_out,
   output logic [1:0][21:0]       feedback_denominator_out,
   output logic [1:0]             output_source_mux_out
);
   localparam int unsigned NSYNC = 4;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [NSYNC-1:0] async_in;
   logic [8:0]       ctrl_q;
   logic [1:0][30:0] div_q;
   logic [1:0][21:0] num_q;
   logic [1:0][21:0] den_q;
   logic [1:0]       mid_level_pin_state;
   logic [1:0]       pin_level_q;
   logic [1:0]       boot_q;
   logic             latched_q;
   logic [1:0]       ref_now;
   logic [1:0]       ref_ok_q;
   logic [15:0]      win_q;
   logic             win_end;
   logic [1:0]       cur_sec;
   logic [1:0]       in_run;
   logic             both_lost;
   logic             sec_path_q;
   logic             any_auto;
   logic [31:0]      rd_mux;
   logic [31:0]      status_w;

   // Reference edges are only ever seen through these, so anything faster
   // than about a quarter of the core clock aliases and may read absent.
   // Two-stage synchronisers for every asynchronous input
   assign async_in = {pin_above_mid_in, pin_above_low_in,
                      secondary_reference_in, primary_reference_in};
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end
   assign ref_now = sync2_q[1:0];

   // Select pin decode: above-mid comparator set is high, above-low alone is mid
   assign mid_level_pin_state = sync2_q[3] ? plris_pkg::PIN_HIGH :
                                sync2_q[2] ? plris_pkg::PIN_MID : plris_pkg::PIN_LOW; // [R21]

   // Later pin moves are ignored on purpose: a mode change mid-run would
   // move both selectors at once, though each still parks low and breaks before make.
   // Pin level is caught once, after the synchronisers have filled
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         boot_q      <= '0;
         latched_q   <= 1'b0;
         pin_level_q <= plris_pkg::PIN_LOW;
      end else if (!latched_q) begin
         boot_q <= boot_q + 2'h1;
         if (boot_q == plris_pkg::BOOT_LATCH) begin
            latched_q   <= 1'b1;
            pin_level_q <= mid_level_pin_state; // [R21]
         end
      end
   end

   // One window serves both monitors; loss is seen one to two windows late,
   // which bounds how long a dead primary keeps feeding the PLL.
   // Shared monitor window in core clocks
   assign win_end = (win_q == 16'(plris_pkg::MON_WIN_CYC - 1));
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         win_q <= '0;
      end else begin
         win_q <= win_end ? 16'h0000 : win_q + 16'h0001;
      end
   end

   // Per-reference activity monitor: a window without a rising edge means absent.
   // A stopped reference may rest high or low; only edges count, so either reads absent.
   generate
      for (genvar r = 0; r < 2; r++) begin : g_mon
         logic edge_w;
         logic prev_q;
         logic seen_q;
         logic ok_q;
         assign edge_w = ref_now[r] & ~prev_q;
         // An edge in the closing cycle still counts for the window it ends
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               prev_q <= 1'b0;
               seen_q <= 1'b0;
               ok_q   <= 1'b0;
            end else begin
               prev_q <= ref_now[r];
               if (win_end) begin
                  ok_q   <= seen_q | edge_w; // [R22]
                  seen_q <= 1'b0;
               end else if (edge_w) begin
                  seen_q <= 1'b1;
               end
            end
         end
         assign ref_ok_q[r] = ok_q;
      end
   endgenerate
   // Both lost is a level, not sticky: it drops once a window sees an edge
   assign both_lost = ~ref_ok_q[0] & ~ref_ok_q[1];

   // Per-PLL selector
   generate
      for (genvar p = 0; p < 2; p++) begin : g_sel
         logic [1:0]             mode_w;
         logic                   auto_w;
         logic                   force_sec_w;
         logic                   tgt_w;
         logic                   src_w;
         plris_pkg::plris_sel_t  st_q;
         plris_pkg::plris_sel_t  st_d;
         logic                   cur_q;
         logic                   cur_d;
         logic                   out_q;
         logic                   out_d;
         logic                   mute_q;
         assign mode_w = ctrl_q[2*p +: 2]; // [R23]
         // Mode decode; pin mid keeps the first PLL automatic, second on secondary
         assign auto_w = (mode_w == plris_pkg::MODE_AUTO) |                 // [R15]
                         ((mode_w == plris_pkg::MODE_PIN) &                 // [R16]
                          ((pin_level_q == plris_pkg::PIN_HIGH) |
                           ((pin_level_q == plris_pkg::PIN_MID) & (p == 0))));
         assign force_sec_w = (mode_w == plris_pkg::MODE_SEC) |
                              ((mode_w == plris_pkg::MODE_PIN) & (p == 1) &
                               (pin_level_q != plris_pkg::PIN_HIGH));      // [R16]
         // Auto prefers primary; with both lost it stays on secondary
         assign tgt_w = auto_w ? ~ref_ok_q[0] : force_sec_w; // [R10] [R11] [R12]
         assign src_w = cur_q ? ref_now[1] : ref_now[0];

         // Trade-off: a switch costs up to one reference period of low output,
         // but the PLL never sees a shortened high phase; only the low phase across a switch can be shorter.
         // Break before make: park low on the old source, adopt the new while low
         always_comb begin
            st_d  = st_q;
            cur_d = cur_q;
            out_d = out_q;
            unique case (st_q)
               plris_pkg::SEL_RUN: begin
                  out_d = src_w;
                  if (tgt_w != cur_q) begin
                     st_d  = plris_pkg::SEL_PARK;
                     out_d = out_q & src_w; // [R9]
                  end
               end
               plris_pkg::SEL_PARK: begin
                  out_d = out_q & src_w; // [R9]
                  if (!out_q) begin
                     cur_d = tgt_w;
                     st_d  = plris_pkg::SEL_WAIT;
                  end
               end
               plris_pkg::SEL_WAIT: begin
                  out_d = 1'b0;
                  cur_d = tgt_w;
                  if (!src_w) begin
                     st_d = plris_pkg::SEL_RUN; // [R9]
                  end
               end
            endcase
         end

         // Reset waits on primary with the output low and the channel muted
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               st_q   <= plris_pkg::SEL_WAIT;
               cur_q  <= 1'b0;
               out_q  <= 1'b0;
               mute_q <= 1'b1;
            end else begin
               st_q   <= st_d;
               cur_q  <= cur_d;
               out_q  <= out_d;
               // Selected source invalid or both lost forces the channel low
               mute_q <= ctrl_q[plris_pkg::CTRL_OMUX + p] ?
                         ~ref_ok_q[cur_q] : (~pll_lock_in[p] | both_lost); // [R20] [R13]
            end
         end
         assign pll_ref_out[p]             = out_q; // [R8]
         assign cur_sec[p]                 = cur_q;
         assign in_run[p]                  = (st_q == plris_pkg::SEL_RUN) & auto_w;
         assign channel_mute_enable_out[p] = mute_q;
         assign output_source_mux_out[p]   = ctrl_q[plris_pkg::CTRL_OMUX + p]; // [R7]

         // Pre, reference and output divider fields hold ratio minus one, so every
         // code is legal and no clamp is needed there.
         // Legalised divider settings
         assign pre_div_out[p]  = div_q[p][plris_pkg::DIV_PRE_LSB +: 3];  // [R2]
         assign doubler_en_out[p] = ctrl_q[plris_pkg::CTRL_DBL + p];      // [R4]
         assign ref_div_out[p]  = div_q[p][plris_pkg::DIV_REF_LSB +: 5];  // [R3]
         assign post_div_out[p] = (div_q[p][plris_pkg::DIV_POST_LSB +: 3] < plris_pkg::POST_MIN)
                                  ? plris_pkg::POST_MIN
                                  : div_q[p][plris_pkg::DIV_POST_LSB +: 3]; // [R6]
         assign output_divide_value_out[p] = div_q[p][plris_pkg::DIV_OUT_LSB +: 8]; // [R5]
         assign fb_int_out[p] = (div_q[p][plris_pkg::DIV_INT_LSB +: 12] == 12'h000)
                                ? plris_pkg::INT_MIN
                                : div_q[p][plris_pkg::DIV_INT_LSB +: 12]; // [R1]
         assign fb_num_out[p] = num_q[p]; // [R1]
         assign feedback_denominator_out[p] = (den_q[p] == 22'h00_0000)
                                              ? plris_pkg::DEN_MIN : den_q[p]; // [R1]
      end
   endgenerate

   // Keep-alive wins over the shutdown condition, so software can always
   // reopen the path before relying on automatic switching again.
   // Secondary path shuts once both PLLs are on primary, one running automatic, with primary present
   assign any_auto = in_run[0] | in_run[1];
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sec_path_q <= 1'b1;
      end else if (ctrl_q[plris_pkg::CTRL_KEEP]) begin
         sec_path_q <= 1'b1;
      end else if (any_auto & ~cur_sec[0] & ~cur_sec[1] & ref_ok_q[0]) begin
         sec_path_q <= 1'b0; // [R17]
      end
   end
   assign secondary_path_en_out   = sec_path_q;
   assign sel_secondary_out       = cur_sec;
   assign both_refs_lost_flag_out = both_lost; // [R13]
   assign pll_out_disable_out     = both_lost; // [R13]

   // Divider words are ignored beyond bit 30; a zero integer or denominator
   // is legalised on the way out rather than refused here.
   // Register writes; divider fields hold ratio minus one except post and integer
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q <= plris_pkg::CTRL_RESET;
         div_q  <= {2{plris_pkg::DIV_RESET}};
         num_q  <= '0;
         den_q  <= {2{plris_pkg::DEN_MIN}};
      end else if (wr_in) begin
         unique case (addr_in)
            plris_pkg::ADDR_CTRL:     ctrl_q   <= wdata_in[8:0];
            plris_pkg::ADDR_DIV0:     div_q[0] <= wdata_in[30:0];
            plris_pkg::ADDR_DIV0 + 4'h1: div_q[1] <= wdata_in[30:0];
            plris_pkg::ADDR_NUM0:     num_q[0] <= wdata_in[21:0];
            plris_pkg::ADDR_NUM0 + 4'h1: num_q[1] <= wdata_in[21:0];
            plris_pkg::ADDR_DEN0:     den_q[0] <= wdata_in[21:0];
            plris_pkg::ADDR_DEN0 + 4'h1: den_q[1] <= wdata_in[21:0];
            default: ;
         endcase
      end
   end

   // Read decode; unmapped words read zero
   // Status word; bits above the pin level read zero
   assign status_w = {24'h00_0000,
                      pin_level_q,
                      sec_path_q,
                      both_lost,
                      cur_sec,
                      ref_ok_q};
   assign rd_mux = (addr_in == plris_pkg::ADDR_CTRL)       ? {23'h00_0000, ctrl_q} :
                   (addr_in == plris_pkg::ADDR_STATUS)     ? status_w :
                   (addr_in == plris_pkg::ADDR_DIV0)       ? {1'b0, div_q[0]} :
                   (addr_in == plris_pkg::ADDR_DIV0 + 4'h1) ? {1'b0, div_q[1]} :
                   (addr_in == plris_pkg::ADDR_NUM0)       ? {10'h000, num_q[0]} :
                   (addr_in == plris_pkg::ADDR_NUM0 + 4'h1) ? {10'h000, num_q[1]} :
                   (addr_in == plris_pkg::ADDR_DEN0)       ? {10'h000, den_q[0]} :
                   (addr_in == plris_pkg::ADDR_DEN0 + 4'h1) ? {10'h000, den_q[1]} :
                   32'h0000_0000;
   // Read data stands one cycle only; it is zero whenever no read was strobed,
   // which keeps a missed strobe from looking like a stale register.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
      end
   end
endmodule

// *** rtl/plris_pkg.sv ***
/*
 Constants for the dual PLL reference input selector: register map, field
 positions, legal divider ranges and monitor timing.
 Assumes a 100 MHz core clock and a plain one-cycle register port.
*/
// Contract
// [R1] Feedback divider: integer 1..4095, numerator 0..4194303, denominator 1..4194303.
// [R2] Primary path divider 1..8 in 3 bits; secondary path undivided.
// [R3] Each PLL has a 5-bit reference divider 1..32 after the doubler.
// [R4] Doubler multiplies by 1 when off, 2 when on.
// [R5] Each output channel divider is 8 bits, ratio 1..256.
// [R6] Post-divider takes 2..8 between VCO and output divider; the 3-bit field here gives 2..7 only.
// [R7] Output follows reference or VCO/(post x output divider) per source mux.
// [R8] Each PLL has its own selector, moded by select pin or register.
// [R9] Switching between references never glitches the selector output.
// [R10] Auto mode leaves a lost primary for the secondary by itself.
// [R11] Auto mode returns to primary once it is present again.
// [R12] With both lost, auto mode waits on the secondary.
// [R13] Both lost raises the lost flag and disables PLL outputs.
// [R14] Sources keep within 2000 ppm of each other for auto switching.
// [R15] Mode 00 auto prefer primary, 10 force primary, 11 force secondary.
// [R16] Mode 01: select pin low, mid or high picks per-PLL behaviour.
// [R17] Auto, keep-alive clear: secondary path off after returning to primary.
// [R18] Software sets keep-alive, low bandwidth, mute bypass clear for switching.
// [R19] Software clears mute bypass of unmuted outputs.
// [R20] Invalid selected source mutes the output, forced low.
// [R21] Three-level pin decoded low, mid, high and latched at reset.
// [R22] Activity monitor counts edges per window; none means absent.
// [R23] Low mode bits steer the first PLL, high bits the second.
package plris_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   // Register word addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_DIV0   = 4'h2;
   localparam logic [3:0] ADDR_NUM0   = 4'h4;
   localparam logic [3:0] ADDR_DEN0   = 4'h6;
   // Control fields
   localparam int unsigned CTRL_KEEP  = 4;
   localparam int unsigned CTRL_DBL   = 5;
   localparam int unsigned CTRL_OMUX  = 7;
   localparam logic [8:0]  CTRL_RESET = 9'h000;
   // Divider word fields
   localparam int unsigned DIV_PRE_LSB  = 0;
   localparam int unsigned DIV_REF_LSB  = 3;
   localparam int unsigned DIV_POST_LSB = 8;
   localparam int unsigned DIV_OUT_LSB  = 11;
   localparam int unsigned DIV_INT_LSB  = 19;
   localparam logic [30:0] DIV_RESET    = 31'h0008_0200;
   // Legal minimums
   localparam logic [2:0]  POST_MIN = 3'h2;
   localparam logic [11:0] INT_MIN  = 12'h001;
   localparam logic [21:0] DEN_MIN  = 22'h00_0001;
   // Mode field codes
   localparam logic [1:0] MODE_AUTO = 2'h0;
   localparam logic [1:0] MODE_PIN  = 2'h1;
   localparam logic [1:0] MODE_PRI  = 2'h2;
   localparam logic [1:0] MODE_SEC  = 2'h3;
   // Pin levels
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_MID = 2'h1;
   localparam logic [1:0] PIN_HIGH = 2'h2;
   // Activity monitor window
   localparam int unsigned CLK_MHZ    = 100;
   localparam int unsigned MON_WIN_NS = 640;
   localparam int unsigned MON_WIN_CYC = MON_WIN_NS * CLK_MHZ / 1000;
   localparam logic [1:0] BOOT_LATCH = 2'h3;
   typedef enum logic [1:0] {SEL_RUN, SEL_PARK, SEL_WAIT} plris_sel_t;
endpackage

// *** sim/plris_props.sv ***
/*
 Port assertions for the dual reference input selector.
 Assumes the bind below and reference clocks slower than four core cycles.
*/
`timescale 1ns/1ps
module plris_props (
   input wire logic             core_clk_in,
   input wire logic             rst_n_in,
   input wire logic             wr_in,
   input wire logic             rd_in,
   input wire logic [31:0]      rdata_out,
   input wire logic [1:0]       pll_lock_in,
   input wire logic [1:0]       pll_ref_out,
   input wire logic [1:0]       sel_secondary_out,
   input wire logic             both_refs_lost_flag_out,
   input wire logic             pll_out_disable_out,
   input wire logic [1:0]       channel_mute_enable_out,
   input wire logic [1:0][4:0]  ref_div_out,
   input wire logic [1:0][2:0]  post_div_out,
   input wire logic [1:0][11:0] fb_int_out,
   input wire logic [1:0][21:0] feedback_denominator_out,
   input wire logic [1:0]       output_source_mux_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Zero divisors would stall the loop, so they must never leave the block
   AST_DEN_NZ: assert property (feedback_denominator_out[0] != 22'h0
      && feedback_denominator_out[1] != 22'h0)
      else $error("denominator zero");
   AST_INT_NZ: assert property (fb_int_out[0] != 12'h0 && fb_int_out[1] != 12'h0)
      else $error("integer zero");
   AST_POST_MIN: assert property (post_div_out[0] >= 3'h2 && post_div_out[1] >= 3'h2)
      else $error("post divider below two");
   AST_REFDIV_HOLD: assert property (!$past(wr_in) |-> $stable(ref_div_out))
      else $error("reference divider moved without write");
   AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data outside read cycle");
   // A runt high pulse is what a bad switchover would show
   AST_NO_RUNT0: assert property ($rose(pll_ref_out[0]) |=> pll_ref_out[0])
      else $error("runt pulse on first selector");
   AST_NO_RUNT1: assert property ($rose(pll_ref_out[1]) |=> pll_ref_out[1])
      else $error("runt pulse on second selector");
   AST_SWAP_LOW: assert property ($changed(sel_secondary_out[0]) |-> !pll_ref_out[0])
      else $error("source swapped while output high");
   AST_LOST_OFF: assert property (both_refs_lost_flag_out == pll_out_disable_out)
      else $error("lost flag and disable differ");
   AST_MUTE_BAD: assert property (!output_source_mux_out[0]
      && (!pll_lock_in[0] || both_refs_lost_flag_out) |=> channel_mute_enable_out[0])
      else $error("invalid source not muted");
   COV_SWAP: cover property ($rose(sel_secondary_out[0]));
   COV_LOST: cover property ($rose(both_refs_lost_flag_out));
   COV_UNMUTE: cover property ($fell(channel_mute_enable_out[0]));
endmodule
bind plris_top plris_props plris_props_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pll_lock_in(pll_lock_in),
   .pll_ref_out(pll_ref_out), .sel_secondary_out(sel_secondary_out),
   .both_refs_lost_flag_out(both_refs_lost_flag_out), .pll_out_disable_out(pll_out_disable_out),
   .channel_mute_enable_out(channel_mute_enable_out), .ref_div_out(ref_div_out),
   .post_div_out(post_div_out), .fb_int_out(fb_int_out),
   .feedback_denominator_out(feedback_denominator_out),
   .output_source_mux_out(output_source_mux_out));

// *** sim/plris_ref_src.sv ***
/*
 Model of the two reference clock sources.
 Assumes the bench switches each source on and off; a stopped source rests low.
*/
`timescale 1ns/1ps
module plris_ref_src (
   input  wire logic pri_en_in,
   input  wire logic sec_en_in,
   output logic      primary_out,
   output logic      secondary_out
);
   initial primary_out = 1'b0;
   initial secondary_out = 1'b0;
   // Periods 1000 ppm apart, unrelated phase, slow enough for the monitor
   always #40.0 primary_out = pri_en_in && !primary_out;
   always #40.04 secondary_out = sec_en_in && !secondary_out;
endmodule

// *** sim/pll_reference_input_selector_tb.sv ***
/*
 Self-checking bench for the reference selector: register port, dividers,
 automatic and forced switching, pin modes and muting.
 Assumes plris_top, its package and the source model beside it.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_count++; \
   $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module pll_reference_input_selector_tb;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, lo = 1'b1, mid = 1'b1;
   logic pe = 1'b1, se = 1'b1, pri, sec;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] lock = 2'h3, sel, mute, mux, dbl, pref;
   logic [1:0][2:0] pre, post;
   logic [1:0][4:0] rdiv;
   logic [1:0][7:0] odiv;
   logic [1:0][11:0] fint;
   logic [1:0][21:0] num, feedback_denominator;
   logic lost, dis, spath;
   int err_count = 0, total_checks = 0;
   always #5 clk = !clk;
   plris_ref_src plris_ref_src_i (.pri_en_in(pe), .sec_en_in(se), .primary_out(pri),
      .secondary_out(sec));
   plris_top plris_top_i (.core_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .primary_reference_in(pri),
      .secondary_reference_in(sec), .pin_above_low_in(lo), .pin_above_mid_in(mid),
      .pll_lock_in(lock), .pll_ref_out(pref), .sel_secondary_out(sel),
      .both_refs_lost_flag_out(lost), .pll_out_disable_out(dis), .secondary_path_en_out(spath),
      .channel_mute_enable_out(mute), .pre_div_out(pre), .doubler_en_out(dbl),
      .ref_div_out(rdiv), .post_div_out(post), .output_divide_value_out(odiv),
      .fb_int_out(fint), .fb_num_out(num), .feedback_denominator_out(feedback_denominator),
      .output_source_mux_out(mux));
   // Reset with the select pin set first, since it is latched after release
   task do_reset(input logic [1:0] lvl);
      lo <= (lvl != plris_pkg::PIN_LOW);
      mid <= (lvl == plris_pkg::PIN_HIGH);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
   task wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data is valid only in the cycle after the strobe
   task rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait on the selection; loss takes up to two monitor windows
   task wait_sel(input logic [1:0] ex);
      int n;
      n = 0;
      while (sel !== ex && n < 600) begin
         cyc(1);
         n++;
      end
      `CHK("sel", ex, sel)
   endtask
   task complete_run();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #500_000;
      err_count++;
      complete_run();
   end
   initial begin
      logic [1:0] run_t [3], lost_t [3];
      run_t = '{2'h2, 2'h2, 2'h0};
      lost_t = '{2'h2, 2'h3, 2'h3};
      do_reset(plris_pkg::PIN_HIGH);
      `CHK("mute", 2'h3, mute)
      `CHK("spath", 1'b1, spath)
      `CHK("den", {22'h1, 22'h1}, feedback_denominator)
      rd_reg(plris_pkg::ADDR_DIV0, d);
      `CHK("div0", 32'h0008_0200, d)
      rd_reg(4'hF, d);
      `CHK("unmapped", 32'h0, d)
      wr_reg(plris_pkg::ADDR_DIV0, 32'hFFFF_FFFF);
      wr_reg(4'h3, 32'h0);
      wr_reg(plris_pkg::ADDR_NUM0, 32'hFFFF_FFFF);
      wr_reg(plris_pkg::ADDR_DEN0, 32'hFFFF_FFFF);
      wr_reg(4'h7, 32'h0);
      wr_reg(plris_pkg::ADDR_CTRL, 32'h160);
      rd_reg(plris_pkg::ADDR_DIV0, d);
      `CHK("div0", 32'h7FFF_FFFF, d)
      `CHK("pre", {3'h0, 3'h7}, pre)
      `CHK("rdiv", {5'h0, 5'h1F}, rdiv)
      `CHK("post", {3'h2, 3'h7}, post)
      `CHK("odiv", {8'h0, 8'hFF}, odiv)
      `CHK("int", {12'h1, 12'hFFF}, fint)
      `CHK("num", {22'h0, 22'h3F_FFFF}, num)
      `CHK("den", {22'h1, 22'h3F_FFFF}, feedback_denominator)
      `CHK("dbl", 2'h3, dbl)
      `CHK("mux", 2'h2, mux)
      wr_reg(plris_pkg::ADDR_CTRL, 32'h0);
      cyc(300);
      `CHK("lost", 1'b0, lost)
      wait_sel(2'h0);
      `CHK("spath", 1'b0, spath)
      `CHK("mute", 2'h0, mute)
      lock[0] <= 1'b0;
      cyc(3);
      `CHK("mute", 2'h1, mute)
      lock[0] <= 1'b1;
      wr_reg(plris_pkg::ADDR_CTRL, 32'h10);
      cyc(3);
      `CHK("spath", 1'b1, spath)
      pe <= 1'b0;
      wait_sel(2'h3);
      rd_reg(plris_pkg::ADDR_STATUS, d);
      `CHK("ok", 2'h2, d[1:0])
      pe <= 1'b1;
      wait_sel(2'h0);
      pe <= 1'b0;
      se <= 1'b0;
      cyc(300);
      `CHK("lost", 1'b1, lost)
      `CHK("dis", 1'b1, dis)
      `CHK("sel", 2'h3, sel)
      `CHK("pref", 2'h0, pref)
      pe <= 1'b1;
      se <= 1'b1;
      wr_reg(plris_pkg::ADDR_CTRL, 32'hF);
      wait_sel(2'h3);
      pe <= 1'b0;
      wr_reg(plris_pkg::ADDR_CTRL, 32'hA);
      cyc(300);
      `CHK("sel", 2'h0, sel)
      pe <= 1'b1;
      // Pin levels low, mid, high with references present and primary lost
      for (int i = 0; i < 3; i++) begin
         do_reset(i[1:0]);
         wr_reg(plris_pkg::ADDR_CTRL, 32'h5);
         cyc(300);
         `CHK("sel", run_t[i], sel)
         rd_reg(plris_pkg::ADDR_STATUS, d);
         `CHK("pin", i[1:0], d[7:6])
         pe <= 1'b0;
         cyc(300);
         `CHK("sel", lost_t[i], sel)
         pe <= 1'b1;
      end
      complete_run();
   end
endmodule
